// [src/fbmc_host.sv]
// Host controller driving the flash strobes, address, data and reset pins
`timescale 1ns/1ps
// Function
// - Writes drive write strobe and chip select low, output enable high
// - Standby when select and reset high; first read waits chip-select access
// - Reset low for minimum width aborts, tristates, returns to array read
// - Caller restarts operations interrupted by hardware reset
// - Idle reset completes in idle time; wait recovery after reset high
// - Elevated voltage on A9, A6 low, A1:A0 select maker, device or sector protection
module fbmc_host
    import fbmc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire fbmc_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_data,
    output logic [2:0] rsp_sector,
    output logic rsp_protected,
    output logic dev_busy,
    output fbmc_ctl_t ctl,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] dq_out,
    output logic [DATA_W-1:0] dq_oe_b,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic ready_busy_out
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        FBMC_ST_IDLE = 3'h0,
        FBMC_ST_RD = 3'h1,
        FBMC_ST_WR = 3'h2,
        FBMC_ST_WR_END = 3'h3,
        FBMC_ST_RST_LOW = 3'h4,
        FBMC_ST_RST_WAIT = 3'h5,
        FBMC_ST_RECOVER = 3'h6
    } fbmc_state_t;

    fbmc_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic standby_q, standby_d;
    logic was_busy_q, was_busy_d;
    fbmc_req_t cur_q, cur_d;
    logic req_ready_q, req_ready_d;
    logic rsp_valid_q, rsp_valid_d;
    logic [DATA_W-1:0] rsp_data_q, rsp_data_d;
    logic rsp_prot_q, rsp_prot_d;
    fbmc_ctl_t ctl_q, ctl_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] dq_out_q, dq_out_d;
    logic [DATA_W-1:0] dq_oe_b_q, dq_oe_b_d;
    logic busy_q;
    logic [2:0] sector_w;
    logic [2:0] sector_q;

    fbmc_sector_dec u_dec (
        .a_hi(cur_q.addr[ADDR_W-1:SECTOR_LSB_POS]),
        .boot_top(cur_q.boot_top),
        .sector_index(sector_w)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        standby_d = standby_q;
        was_busy_d = was_busy_q;
        cur_d = cur_q;
        req_ready_d = 1'b0;
        rsp_valid_d = 1'b0;
        rsp_data_d = rsp_data_q;
        rsp_prot_d = rsp_prot_q;
        ctl_d = ctl_q;
        addr_d = addr_q;
        dq_out_d = dq_out_q;
        dq_oe_b_d = {DATA_W{1'b1}};
        unique case (state_q)
            FBMC_ST_IDLE:
            begin
                // Park in standby: select and reset high, strobes high
                ctl_d.ce_b = 1'b1;
                ctl_d.oe_b = 1'b1;
                ctl_d.we_b = 1'b1;
                ctl_d.reset_b = 1'b1;
                ctl_d.id_hv = 1'b0;
                standby_d = 1'b1;
                req_ready_d = 1'b1;
                if (req_valid && req_ready_q)
                begin
                    cur_d = req;
                    req_ready_d = 1'b0;
                    ctl_d.byte_b = ~req.byte_mode;
                    addr_d = req.addr;
                    if (req.byte_mode)
                    begin
                        // Byte address lsb on DQ15
                        dq_out_d[DATA_W-1] = req.addr_lsb;
                        dq_oe_b_d[DATA_W-1] = 1'b0;
                    end
                    unique case (req.op)
                        FBMC_OP_READ, FBMC_OP_IDREAD:
                        begin
                            // Full select access after standby
                            cnt_d = CNT_W'(standby_q ? T_CE_CYC : T_ACC_CYC);
                            ctl_d.ce_b = 1'b0;
                            ctl_d.oe_b = 1'b0;
                            if (req.op == FBMC_OP_IDREAD)
                            begin
                                // A9 raised, A6 low; A1:A0 from request
                                ctl_d.id_hv = 1'b1;
                                addr_d[AS_A6_POS] = 1'b0;
                            end
                            state_d = FBMC_ST_RD;
                        end
                        FBMC_OP_WRITE:
                        begin
                            // Output enable high before strobes fall
                            ctl_d.oe_b = 1'b1;
                            ctl_d.ce_b = 1'b0;
                            ctl_d.we_b = 1'b0;
                            dq_out_d = req.byte_mode ?
                                {req.addr_lsb, 7'h00, req.wdata[7:0]} : req.wdata;
                            dq_oe_b_d = req.byte_mode ? 16'h7F00 : 16'h0000;
                            cnt_d = CNT_W'(T_WP_CYC);
                            state_d = FBMC_ST_WR;
                        end
                        default:
                        begin
                            // Hardware reset; latch busy to choose wait time
                            ctl_d.reset_b = 1'b0;
                            was_busy_d = busy_q;
                            cnt_d = CNT_W'(RST_PULSE_CYC);
                            state_d = FBMC_ST_RST_LOW;
                        end
                    endcase
                    standby_d = 1'b0;
                end
            end
            FBMC_ST_RD:
            begin
                dq_oe_b_d = {DATA_W{1'b1}};
                if (cur_q.byte_mode)
                    dq_oe_b_d[DATA_W-1] = 1'b0;
                if (cnt_q > CNT_W'(1))
                    cnt_d = cnt_q - CNT_W'(1);
                else
                begin
                    // Identification and status codes on low byte
                    rsp_data_d = cur_q.byte_mode ? {8'h00, dq_in[7:0]} : dq_in;
                    rsp_prot_d = (cur_q.op == FBMC_OP_IDREAD) &&
                        (cur_q.addr[1:0] == AS_SEL_PROT) && (dq_in[7:0] != PROT_NO);
                    rsp_valid_d = 1'b1;
                    ctl_d.oe_b = 1'b1;
                    ctl_d.ce_b = 1'b1;
                    ctl_d.id_hv = 1'b0;
                    state_d = FBMC_ST_IDLE;
                end
            end
            FBMC_ST_WR:
            begin
                dq_oe_b_d = dq_oe_b_q;
                if (cnt_q > CNT_W'(1))
                    cnt_d = cnt_q - CNT_W'(1);
                else
                begin
                    // Both strobes rise together; data held one more cycle
                    ctl_d.we_b = 1'b1;
                    ctl_d.ce_b = 1'b1;
                    state_d = FBMC_ST_WR_END;
                end
            end
            FBMC_ST_WR_END:
            begin
                rsp_valid_d = 1'b1;
                state_d = FBMC_ST_IDLE;
            end
            FBMC_ST_RST_LOW:
            begin
                if (cnt_q > CNT_W'(1))
                    cnt_d = cnt_q - CNT_W'(1);
                else
                begin
                    ctl_d.reset_b = 1'b1;
                    cnt_d = CNT_W'(was_busy_q ? T_READY_BUSY_CYC : T_READY_IDLE_CYC);
                    state_d = FBMC_ST_RST_WAIT;
                end
            end
            FBMC_ST_RST_WAIT:
            begin
                if (cnt_q > CNT_W'(1))
                    cnt_d = cnt_q - CNT_W'(1);
                if (cnt_q <= CNT_W'(1) && ready_busy_out)
                begin
                    cnt_d = CNT_W'(RST_RECOV_CYC);
                    state_d = FBMC_ST_RECOVER;
                end
            end
            FBMC_ST_RECOVER:
            begin
                if (cnt_q > CNT_W'(1))
                    cnt_d = cnt_q - CNT_W'(1);
                else
                begin
                    // Caller reissues interrupted work after this pulse
                    rsp_valid_d = 1'b1;
                    state_d = FBMC_ST_IDLE;
                end
            end
            default:
                state_d = FBMC_ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            state_q <= FBMC_ST_IDLE;
            cnt_q <= '0;
            standby_q <= 1'b1;
            was_busy_q <= 1'b0;
            cur_q <= '0;
            req_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= '0;
            rsp_prot_q <= 1'b0;
            ctl_q <= 6'h3E;
            addr_q <= '0;
            dq_out_q <= '0;
            dq_oe_b_q <= 16'hFFFF;
            busy_q <= 1'b0;
            sector_q <= 3'h0;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            standby_q <= standby_d;
            was_busy_q <= was_busy_d;
            cur_q <= cur_d;
            req_ready_q <= req_ready_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
            rsp_prot_q <= rsp_prot_d;
            ctl_q <= ctl_d;
            addr_q <= addr_d;
            dq_out_q <= dq_out_d;
            dq_oe_b_q <= dq_oe_b_d;
            busy_q <= ~ready_busy_out;
            // Sector of last request, for erase targeting by caller
            sector_q <= sector_w;
        end
    end

    assign req_ready = req_ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign rsp_sector = sector_q;
    assign rsp_protected = rsp_prot_q;
    assign dev_busy = busy_q;
    assign ctl = ctl_q;
    assign addr = addr_q;
    assign dq_out = dq_out_q;
    assign dq_oe_b = dq_oe_b_q;

    ////////////////////////////////////////////////////////////////////////
    chk_write_strobes: assert property (@(posedge clock) disable iff (!rst_b)
        !ctl_q.we_b |-> (!ctl_q.ce_b && ctl_q.oe_b))
        else $error("write strobe low without select low and output enable high");
    chk_read_no_drive: assert property (@(posedge clock) disable iff (!rst_b)
        !ctl_q.oe_b |-> (dq_oe_b_q[14:0] == 15'h7FFF))
        else $error("host drives data while device outputs enabled");
    chk_reset_width: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && $fell(ctl_q.reset_b)) |=> !ctl_q.reset_b [*8])
        else $error("reset pulse too short");
    chk_recover_wait: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && state_q == FBMC_ST_RST_WAIT && state_d == FBMC_ST_RECOVER)
        |=> (ctl_q.ce_b && ctl_q.reset_b) [*8])
        else $error("device selected during reset recovery");
    chk_idread_pins: assert property (@(posedge clock) disable iff (!rst_b)
        ctl_q.id_hv |-> (!addr_q[AS_A6_POS] && !ctl_q.oe_b))
        else $error("identification without A6 low and read");
    chk_byte_upper: assert property (@(posedge clock) disable iff (!rst_b)
        (state_q == FBMC_ST_WR && cur_q.byte_mode) |-> (dq_oe_b_q[14:8] == 7'h7F))
        else $error("upper data pins driven in byte mode");
    chk_standby_idle: assert property (@(posedge clock) disable iff (!rst_b)
        (state_q == FBMC_ST_IDLE && $past(state_q) == FBMC_ST_IDLE) |->
        (ctl_q.ce_b && ctl_q.reset_b))
        else $error("idle without standby levels");
    chk_wr_hold: assert property (@(posedge clock) disable iff (!rst_b)
        (state_q == FBMC_ST_WR_END) |-> (ctl_q.we_b && dq_oe_b_q != 16'hFFFF))
        else $error("data released before strobe rise");
endmodule

// [src/fbmc_pkg.sv]
// Package: constants and carriers for the flash bus-mode host controller
package fbmc_pkg;
    localparam int CLK_MHZ = 200;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    // Times in ns
    localparam int T_ACC_NS = 70;
    localparam int T_CE_NS = 70;
    localparam int T_WP_NS = 35;
    localparam int RST_PULSE_NS = 500;
    localparam int RST_RECOV_NS = 50;
    localparam int T_READY_BUSY_NS = 20000;
    localparam int T_READY_IDLE_NS = 500;
    localparam int T_ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int T_CE_CYC = (T_CE_NS * CLK_MHZ + 999) / 1000;
    localparam int T_WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_RECOV_CYC = (RST_RECOV_NS * CLK_MHZ + 999) / 1000;
    localparam int T_READY_BUSY_CYC = (T_READY_BUSY_NS * CLK_MHZ + 999) / 1000;
    localparam int T_READY_IDLE_CYC = (T_READY_IDLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 13;
    // Autoselect address fields
    localparam int AS_A0_POS = 0;
    localparam int AS_A1_POS = 1;
    localparam int AS_A6_POS = 6;
    localparam int AS_A9_POS = 9;
    localparam int SECTOR_LSB_POS = 12;
    localparam logic [1:0] AS_SEL_MAKER = 2'h0;
    localparam logic [1:0] AS_SEL_DEVICE = 2'h1;
    localparam logic [1:0] AS_SEL_PROT = 2'h2;
    localparam logic [7:0] PROT_YES = 8'h01;
    localparam logic [7:0] PROT_NO = 8'h00;

    typedef enum logic [1:0] {
        FBMC_OP_READ = 2'h0,
        FBMC_OP_WRITE = 2'h1,
        FBMC_OP_RESET = 2'h2,
        FBMC_OP_IDREAD = 2'h3
    } fbmc_op_t;

    typedef struct packed {
        fbmc_op_t op;
        logic byte_mode;
        logic boot_top;
        logic [ADDR_W-1:0] addr;
        logic addr_lsb;
        logic [DATA_W-1:0] wdata;
    } fbmc_req_t;

    typedef struct packed {
        logic ce_b;
        logic oe_b;
        logic we_b;
        logic reset_b;
        logic byte_b;
        logic id_hv;
    } fbmc_ctl_t;
endpackage

// [src/fbmc_sector_dec.sv]
// Sector decode for top and bottom boot variants
`timescale 1ns/1ps
module fbmc_sector_dec
    import fbmc_pkg::*;
(
    input wire logic [3:0] a_hi,
    input wire logic boot_top,
    output logic [2:0] sector_index
);
    always_comb
    begin
        if (boot_top)
        begin
            if (!a_hi[3])
                sector_index = 3'h0;
            else if (!a_hi[2])
                sector_index = 3'h1;
            else if (!a_hi[1])
                sector_index = a_hi[0] ? 3'h3 : 3'h2;
            else
                sector_index = 3'h4;
        end
        else
        begin
            if (a_hi[3])
                sector_index = 3'h4;
            else if (a_hi[2])
                sector_index = 3'h3;
            else if (!a_hi[1])
                sector_index = 3'h0;
            else
                sector_index = a_hi[0] ? 3'h2 : 3'h1;
        end
    end
endmodule

// [test/fbmc_flash_model.sv]
// Behavioural flash device answering the host controller
`timescale 1ns/1ps
module fbmc_flash_model
    import fbmc_pkg::*;
#(
    parameter logic [7:0] MAKER = 8'h5A, // Arbitrary value
    parameter logic [15:0] DEV_ID = 16'h3C7E, // Arbitrary value
    parameter logic [4:0] PROT = 5'h04,
    parameter logic [15:0] STAT = 16'h00A5,
    parameter int BUSY_LEN = 60,
    parameter int RST_LEN = 30
)
(
    input wire logic clock,
    input wire fbmc_ctl_t ctl,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic [DATA_W-1:0] dq_oe_b,
    output logic [DATA_W-1:0] dq_in,
    output logic ready_busy_out
);
    logic [15:0] mem [256];
    logic [15:0] dev, den, w, m;
    logic [15:0] last_q = 16'h0000;
    logic [15:0] a_q = 16'h0000;
    logic wr;
    logic wr_q = 1'b0;
    int acc_q = 0;
    int busy_q = 0;
    int rst_q = 0;
    initial
        foreach (mem[i]) mem[i] = 16'h0000;
    ////////////////////////////////////////////////////////////////
    // Top-boot decode only
    function automatic logic [2:0] sec(input logic [3:0] a);
        return !a[3] ? 3'h0 : !a[2] ? 3'h1 : a[1] ? 3'h4 : {2'h1, a[0]};
    endfunction
    always_comb
    begin
        dev = 16'h0000;
        den = 16'h0000;
        m = mem[addr[7:0]];
        wr = ctl.reset_b && !ctl.ce_b && !ctl.we_b && ctl.oe_b;
        // Data only after full select access, so an early sample sees junk
        if (ctl.reset_b && !ctl.ce_b && !ctl.oe_b && ctl.we_b && acc_q >= T_CE_CYC - 1)
        begin
            den = ctl.byte_b ? 16'hFFFF : 16'h00FF;
            if (ctl.id_hv && !addr[AS_A6_POS])
                dev = addr[1] ? {15'h0000, PROT[sec(addr[15:12])]}
                    : addr[0] ? DEV_ID : {8'h00, MAKER};
            else if (busy_q != 0)
                dev = STAT;
            else
                dev = (!ctl.byte_b && dq_out[15]) ? {8'h00, m[15:8]} : m;
        end
        // Released lines show the inverse of their last level
        w = (~dq_oe_b & dq_out) | (dq_oe_b & den & dev) | (dq_oe_b & ~den & ~last_q);
    end
    assign dq_in = w;
    assign ready_busy_out = busy_q == 0 && rst_q == 0;
    always @(posedge clock)
    begin
        last_q <= w;
        wr_q <= wr;
        acc_q <= (ctl.ce_b || ctl.oe_b) ? 0 : acc_q + 1;
        rst_q <= rst_q > 0 ? rst_q - 1 : 0;
        busy_q <= busy_q > 0 ? busy_q - 1 : 0;
        if (wr)
            a_q <= addr;
        if (!ctl.reset_b)
        begin
            busy_q <= 0;
            if (busy_q != 0)
                rst_q <= RST_LEN;
        end
        else if (wr_q && !wr)
        begin
            if (ctl.byte_b)
                mem[a_q[7:0]] <= last_q;
            else if (last_q[15])
                mem[a_q[7:0]][15:8] <= last_q[7:0];
            else
                mem[a_q[7:0]][7:0] <= last_q[7:0];
            if (last_q[7:0] == 8'h30)
                busy_q <= BUSY_LEN;
        end
    end
endmodule

// [test/fbmc_host_bench.sv]
// Self-checking bench for the flash bus-mode host controller
`timescale 1ns/1ps
module fbmc_host_bench
    import fbmc_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic clk_en = 1'b1;
    fbmc_req_t req = '0;
    logic req_ready, rsp_valid, rsp_protected, dev_busy, ready_busy_out;
    logic [DATA_W-1:0] rsp_data, dq_out, dq_oe_b, dq_in;
    logic [2:0] rsp_sector;
    fbmc_ctl_t ctl;
    logic [ADDR_W-1:0] addr;
    int n_mismatch = 0;
    int tests_run = 0;
    int bad = 0;
    int rl = 0;
    int rh = 1000;
    always #2.5 clock = ~clock;
    fbmc_host dut (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_sector(rsp_sector), .rsp_protected(rsp_protected), .dev_busy(dev_busy),
        .ctl(ctl), .addr(addr), .dq_out(dq_out), .dq_oe_b(dq_oe_b), .dq_in(dq_in),
        .ready_busy_out(ready_busy_out));
    fbmc_flash_model flash (.clock(clock), .ctl(ctl), .addr(addr), .dq_out(dq_out),
        .dq_oe_b(dq_oe_b), .dq_in(dq_in), .ready_busy_out(ready_busy_out));
    ////////////////////////////////////////////////////////////////
    // Pin monitor; violations counted, judged at the end
    always @(posedge clock)
        if (rst_b)
        begin
            if (!ctl.we_b && (ctl.oe_b !== 1'b1 || ctl.ce_b !== 1'b0)) bad++;
            if (!ctl.reset_b && dq_oe_b !== 16'hFFFF) bad++;
            if (!ctl.oe_b && dq_oe_b[14:0] !== 15'h7FFF) bad++;
            if (!ctl.byte_b && dq_oe_b[14:8] !== 7'h7F) bad++;
            if (ctl.reset_b && rl != 0 && rl < RST_PULSE_CYC) bad++;
            if (!ctl.ce_b && rh < RST_RECOV_CYC) bad++;
            rl = ctl.reset_b ? 0 : rl + 1;
            rh = !ctl.reset_b ? 0 : (rh < 1000 ? rh + 1 : rh);
        end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Holds the request until taken, then waits for the answer pulse
    task automatic op(input fbmc_op_t o, input logic bm, input logic top,
        input logic [15:0] a, input logic lsb, input logic [15:0] wd);
        int n;
        n = 0;
        req <= '{o, bm, top, a, lsb, wd};
        req_valid <= 1'b1;
        do @(posedge clock); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (rsp_valid !== 1'b1 && n < 6000);
        if (n >= 6000)
        begin
            n_mismatch++;
            wrap_up();
        end
    endtask
    function automatic logic [2:0] exp_sec(input logic top, input logic [3:0] a);
        if (top)
            return !a[3] ? 3'h0 : !a[2] ? 3'h1 : a[1] ? 3'h4 : {2'h1, a[0]};
        return a[3] ? 3'h4 : a[2] ? 3'h3 : !a[1] ? 3'h0 : {2'h1, a[0]} - 3'h1;
    endfunction
    ////////////////////////////////////////////////////////////////
    task automatic t_word;
        op(FBMC_OP_WRITE, 1'b0, 1'b1, 16'h0012, 1'b0, 16'hBEEF);
        op(FBMC_OP_WRITE, 1'b0, 1'b1, 16'h0013, 1'b0, 16'h1234);
        op(FBMC_OP_READ, 1'b0, 1'b1, 16'h0012, 1'b0, 16'h0000);
        chk(rsp_data, 16'hBEEF);
        op(FBMC_OP_READ, 1'b0, 1'b1, 16'h0013, 1'b0, 16'h0000);
        chk(rsp_data, 16'h1234);
        $display("word test done");
    endtask
    task automatic t_byte;
        op(FBMC_OP_WRITE, 1'b1, 1'b1, 16'h0020, 1'b1, 16'h005C);
        op(FBMC_OP_WRITE, 1'b1, 1'b1, 16'h0020, 1'b0, 16'h00A3);
        op(FBMC_OP_READ, 1'b1, 1'b1, 16'h0020, 1'b1, 16'h0000);
        chk(rsp_data, 16'h005C);
        op(FBMC_OP_READ, 1'b0, 1'b1, 16'h0020, 1'b0, 16'h0000);
        chk(rsp_data, 16'h5CA3);
        $display("byte test done");
    endtask
    task automatic t_sector;
        for (int i = 0; i < 32; i++)
        begin
            op(FBMC_OP_READ, 1'b0, i[4], {i[3:0], 12'h000}, 1'b0, 16'h0000);
            chk({13'h0, rsp_sector}, {13'h0, exp_sec(i[4], i[3:0])});
        end
        $display("sector test done");
    endtask
    task automatic t_ident;
        logic [15:0] prot_addr [5] = '{16'h0002, 16'h8002, 16'hC002, 16'hD002, 16'hE002};
        op(FBMC_OP_IDREAD, 1'b0, 1'b1, 16'h0000, 1'b0, 16'h0000);
        chk({8'h00, rsp_data[7:0]}, 16'h005A);
        op(FBMC_OP_IDREAD, 1'b0, 1'b1, 16'h0001, 1'b0, 16'h0000);
        chk(rsp_data, 16'h3C7E);
        op(FBMC_OP_IDREAD, 1'b1, 1'b1, 16'h0001, 1'b0, 16'h0000);
        chk(rsp_data, 16'h007E);
        for (int i = 0; i < 5; i++)
        begin
            op(FBMC_OP_IDREAD, 1'b0, 1'b1, prot_addr[i], 1'b0, 16'h0000);
            chk({8'h00, rsp_data[7:0]}, {15'h0, i == 2});
            chk({15'h0, rsp_protected}, {15'h0, i == 2});
        end
        $display("ident test done");
    endtask
    task automatic t_busy;
        int n;
        n = 0;
        op(FBMC_OP_WRITE, 1'b0, 1'b1, 16'h0055, 1'b0, 16'h0030);
        repeat (3) @(posedge clock);
        chk({15'h0, dev_busy}, 16'h0001);
        op(FBMC_OP_READ, 1'b0, 1'b1, 16'h0012, 1'b0, 16'h0000);
        chk(rsp_data, 16'h00A5);
        while (dev_busy !== 1'b0 && n < 200)
        begin
            @(posedge clock);
            n++;
        end
        chk({15'h0, dev_busy}, 16'h0000);
        $display("busy test done");
    endtask
    task automatic t_reset;
        op(FBMC_OP_WRITE, 1'b0, 1'b1, 16'h0055, 1'b0, 16'h0030);
        op(FBMC_OP_RESET, 1'b0, 1'b1, 16'h0000, 1'b0, 16'h0000);
        chk({15'h0, dev_busy}, 16'h0000);
        op(FBMC_OP_RESET, 1'b0, 1'b1, 16'h0000, 1'b0, 16'h0000);
        op(FBMC_OP_WRITE, 1'b0, 1'b1, 16'h0014, 1'b0, 16'h0F0F);
        op(FBMC_OP_READ, 1'b0, 1'b1, 16'h0014, 1'b0, 16'h0000);
        chk(rsp_data, 16'h0F0F);
        op(FBMC_OP_READ, 1'b0, 1'b1, 16'h0012, 1'b0, 16'h0000);
        chk(rsp_data, 16'hBEEF);
        $display("reset test done");
    endtask
    // Enable low mid-read must hold pins; then a mid-run reset
    task automatic t_freeze;
        req <= '{FBMC_OP_READ, 1'b0, 1'b1, 16'h0013, 1'b0, 16'h0000};
        req_valid <= 1'b1;
        do @(posedge clock); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        clk_en <= 1'b0;
        repeat (30) @(posedge clock);
        chk({15'h0, ctl.ce_b}, 16'h0000);
        chk({15'h0, rsp_valid}, 16'h0000);
        clk_en <= 1'b1;
        do @(posedge clock); while (rsp_valid !== 1'b1);
        chk(rsp_data, 16'h1234);
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        chk({10'h000, ctl}, 16'h003E);
        chk(dq_oe_b, 16'hFFFF);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        op(FBMC_OP_READ, 1'b0, 1'b1, 16'h0013, 1'b0, 16'h0000);
        chk(rsp_data, 16'h1234);
        $display("freeze test done");
    endtask
    initial
    begin
        repeat (8) @(posedge clock);
        chk({10'h000, ctl}, 16'h003E);
        chk(dq_oe_b, 16'hFFFF);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        t_word();
        t_byte();
        t_sector();
        t_ident();
        t_busy();
        t_reset();
        t_freeze();
        chk(16'(bad), 16'h0000);
        wrap_up();
    end
    initial
    begin
        #(40000 * 5);
        n_mismatch++;
        wrap_up();
    end
endmodule
